//--- buck_dvs_decay_sequencer.sv
// six-rail voltage-code sequencer with register slave and switch control
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
module buck_dvs_decay_sequencer #(
   parameter int SOFT_START_CYCLES = buck_seq_pkg::SOFT_START_CYC,
   parameter int FINE_CYCLES = buck_seq_pkg::STEP_FINE_CYC,
   parameter int COARSE_CYCLES = buck_seq_pkg::STEP_COARSE_CYC,
   parameter int MIN_ON_CYCLES = buck_seq_pkg::MIN_ON_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // interrupt
   output logic irq,
   // per-rail analog comparator inputs
   input wire logic [buck_seq_pkg::NUM_RAILS-1:0] belowThreshold,
   input wire logic [buck_seq_pkg::NUM_RAILS-1:0] peakLimit,
   input wire logic [buck_seq_pkg::NUM_RAILS-1:0] negLimit,
   input wire logic [buck_seq_pkg::NUM_RAILS-1:0] zeroCross,
   input wire logic [buck_seq_pkg::NUM_RAILS-1:0] outBelowHalfVolt,
   input wire logic [buck_seq_pkg::NUM_RAILS-1:0] outBelowOverVolt,
   input wire logic [buck_seq_pkg::NUM_RAILS-1:0] outAboveCode,
   input wire logic [buck_seq_pkg::NUM_RAILS-1:0] powerGoodRaw,
   // per-rail outputs
   output logic [buck_seq_pkg::NUM_RAILS-1:0] highSide,
   output logic [buck_seq_pkg::NUM_RAILS-1:0] lowSide,
   output logic [buck_seq_pkg::NUM_RAILS-1:0] power_good_flag,
   output logic [buck_seq_pkg::NUM_RAILS-1:0] pwmForced,
   output logic [buck_seq_pkg::NUM_RAILS*buck_seq_pkg::CODE_W-1:0] voltage_id_code
);
   import buck_seq_pkg::*;

   if (SOFT_START_CYCLES < 1 || SOFT_START_CYCLES > 1048575) begin : g_chk
      $error("buck_dvs_decay_sequencer: SOFT_START_CYCLES out of range");
   end

   logic fineTick, coarseTick;
   logic [NUM_RAILS-1:0] moveDone, switchEnable, railMoving, railPwm;
   logic [NUM_RAILS-1:0] ctrlWrite;
   logic [NUM_RAILS-1:0] rail_decay_enable_q, rail_decay_enable_d;
   logic [NUM_RAILS-1:0] stepCoarse_q, stepCoarse_d;
   logic [CODE_W-1:0] rail_target_code_q [NUM_RAILS];
   logic [CODE_W-1:0] rail_target_code_d [NUM_RAILS];
   logic [CODE_W-1:0] railCode [NUM_RAILS];
   logic [NUM_RAILS-1:0] irqStat_q, irqStat_d, irqMask_q, irqMask_d;
   logic waitrequest_d, irq_d;
   logic [31:0] readdata_d;
   logic accessNow, writeNow, readLoad;
   logic [NUM_RAILS-1:0] power_good_flag_d, pwmForced_d;

   // step enables shared by all rails
   step_tick_divider #(
      .FINE_CYCLES(FINE_CYCLES),
      .COARSE_CYCLES(COARSE_CYCLES)
   ) u_ticks (
      .ref_clk(ref_clk),
      .rst(rst),
      .fineTick(fineTick),
      .coarseTick(coarseTick)
   );

   // bus handshake: one wait cycle, write lands at the edge waitrequest is low
   always_comb begin
      accessNow = (read || write) && !waitrequest;
      writeNow = write && !waitrequest;
      readLoad = read && waitrequest;
      waitrequest_d = !((read || write) && waitrequest);
   end

   // control register decode, one word per rail
   always_comb begin
      rail_decay_enable_d = rail_decay_enable_q;
      stepCoarse_d = stepCoarse_q;
      irqMask_d = irqMask_q;
      for (int r = 0; r < NUM_RAILS; r++) begin
         rail_target_code_d[r] = rail_target_code_q[r];
         ctrlWrite[r] = writeNow && (address == ADDR_CTRL_BASE + 8'(4 * r));
         if (ctrlWrite[r] && byteenable[0]) begin
            rail_target_code_d[r] = writedata[CTRL_TARGET_LSB +: CODE_W];
            rail_decay_enable_d[r] = writedata[CTRL_DECAY_BIT];
         end
         if (ctrlWrite[r] && byteenable[1]) begin
            stepCoarse_d[r] = writedata[CTRL_COARSE_BIT];
         end
      end
      if (writeNow && address == ADDR_IRQ_MASK && byteenable[0]) begin
         irqMask_d = writedata[NUM_RAILS-1:0];
      end
   end

   // sticky move-done flags; a new event beats a same-cycle clear
   always_comb begin
      irqStat_d = irqStat_q;
      if (writeNow && address == ADDR_IRQ_STAT && byteenable[0]) begin
         irqStat_d = irqStat_q & ~writedata[NUM_RAILS-1:0];
      end
      irqStat_d = irqStat_d | moveDone;
      irq_d = |(irqStat_d & irqMask_d);
   end

   // read mux; unmapped addresses read as zero
   always_comb begin
      readdata_d = readLoad ? 32'h0000_0000 : readdata;
      if (readLoad) begin
         for (int r = 0; r < NUM_RAILS; r++) begin
            if (address == ADDR_CTRL_BASE + 8'(4 * r)) begin
               readdata_d[CTRL_TARGET_LSB +: CODE_W] = rail_target_code_q[r];
               readdata_d[CTRL_DECAY_BIT] = rail_decay_enable_q[r];
               readdata_d[CTRL_COARSE_BIT] = stepCoarse_q[r];
            end
            if (address == ADDR_STAT_BASE + 8'(4 * r)) begin
               readdata_d[STAT_CODE_LSB +: CODE_W] = railCode[r];
               readdata_d[STAT_MOVING_BIT] = railMoving[r];
               readdata_d[STAT_SWITCHING_BIT] = switchEnable[r];
               readdata_d[STAT_PWM_BIT] = railPwm[r];
            end
         end
         if (address == ADDR_IRQ_STAT) begin
            readdata_d[NUM_RAILS-1:0] = irqStat_q;
         end
         if (address == ADDR_IRQ_MASK) begin
            readdata_d[NUM_RAILS-1:0] = irqMask_q;
         end
      end
   end

   // bus-side registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
         irq <= 1'b0;
         irqStat_q <= '0;
         irqMask_q <= IRQ_MASK_RESET;
         rail_decay_enable_q <= '0;
         stepCoarse_q <= '0;
         for (int r = 0; r < NUM_RAILS; r++) begin
            rail_target_code_q[r] <= TARGET_RESET;
         end
      end else begin
         waitrequest <= waitrequest_d;
         readdata <= readdata_d;
         irq <= irq_d;
         irqStat_q <= irqStat_d;
         irqMask_q <= irqMask_d;
         rail_decay_enable_q <= rail_decay_enable_d;
         stepCoarse_q <= stepCoarse_d;
         for (int r = 0; r < NUM_RAILS; r++) begin
            rail_target_code_q[r] <= rail_target_code_d[r];
         end
      end
   end

   // per-rail code sequencer and switch control
   for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail
      rail_state_type state_q, state_d;
      logic [CODE_W-1:0] code_q, code_d, goal;
      logic [19:0] ssCnt_q, ssCnt_d;
      logic waitCatch_q, waitCatch_d;
      logic tick, done_d;

      // zero target means ramp to minimum code and then stop
      always_comb begin
         tick = stepCoarse_q[g] ? coarseTick : fineTick;
         goal = (rail_target_code_q[g] == CODE_OFF) ? CODE_MIN : rail_target_code_q[g];
      end

      always_comb begin
         state_d = state_q;
         code_d = code_q;
         ssCnt_d = ssCnt_q;
         waitCatch_d = waitCatch_q;
         done_d = 1'b0;
         case (state_q)
            RAIL_OFF: begin
               code_d = CODE_MIN;
               if (goal > CODE_MIN) begin
                  if (outBelowHalfVolt[g]) begin
                     state_d = RAIL_SOFTSTART;
                     ssCnt_d = 20'(SOFT_START_CYCLES - 1);
                  end else begin
                     state_d = RAIL_STEP;
                  end
               end
            end
            RAIL_SOFTSTART: begin
               // target changes here are taken up once stepping begins
               if (ssCnt_q == 20'h00000 && tick) begin
                  code_d = CODE_HALF_VOLT;
                  state_d = RAIL_STEP;
               end else if (ssCnt_q != 20'h00000) begin
                  ssCnt_d = ssCnt_q - 20'h00001;
               end
            end
            RAIL_DECAY: begin
               if (goal > code_q) begin
                  // output may still sit above the code: hold switches off
                  state_d = RAIL_STEP;
                  waitCatch_d = 1'b1;
               end else begin
                  code_d = goal;
                  if (outBelowOverVolt[g]) begin
                     state_d = (rail_target_code_q[g] == CODE_OFF) ? RAIL_OFF : RAIL_IDLE;
                     done_d = 1'b1;
                  end
               end
            end
            RAIL_STEP: begin
               if (waitCatch_q && !outAboveCode[g]) begin
                  waitCatch_d = 1'b0;
               end
               if (goal < code_q && rail_decay_enable_q[g]) begin
                  state_d = RAIL_DECAY;
                  code_d = goal;
                  waitCatch_d = 1'b0;
               end else if (goal == code_q) begin
                  state_d = (rail_target_code_q[g] == CODE_OFF) ? RAIL_OFF : RAIL_IDLE;
                  done_d = 1'b1;
                  waitCatch_d = 1'b0;
               end else if (tick) begin
                  // redirect from present code on any target change
                  code_d = (goal > code_q) ? code_q + 7'h01 : code_q - 7'h01;
               end
            end
            RAIL_IDLE: begin
               if (goal != code_q) begin
                  if (goal < code_q && rail_decay_enable_q[g]) begin
                     state_d = RAIL_DECAY;
                     code_d = goal;
                  end else begin
                     state_d = RAIL_STEP;
                  end
               end
            end
            default: begin
               state_d = RAIL_OFF;
            end
         endcase
      end

      always_ff @(posedge ref_clk) begin
         if (rst) begin
            state_q <= RAIL_OFF;
            code_q <= CODE_MIN;
            ssCnt_q <= 20'h00000;
            waitCatch_q <= 1'b0;
            moveDone[g] <= 1'b0;
         end else begin
            state_q <= state_d;
            code_q <= code_d;
            ssCnt_q <= ssCnt_d;
            waitCatch_q <= waitCatch_d;
            moveDone[g] <= done_d;
         end
      end

      // decay, the stopped state and the catch-up wait keep both switches off
      always_comb begin
         railCode[g] = code_q;
         railMoving[g] = (state_q == RAIL_STEP) || (state_q == RAIL_SOFTSTART) || (state_q == RAIL_DECAY);
         switchEnable[g] = (state_q != RAIL_OFF) && (state_q != RAIL_DECAY) && !waitCatch_q;
         railPwm[g] = railMoving[g] && !rail_decay_enable_q[g];
         power_good_flag_d[g] = powerGoodRaw[g] && (state_q == RAIL_IDLE);
         pwmForced_d[g] = railPwm[g];
      end

      rail_switch_ctrl #(
         .MIN_ON_CYCLES(MIN_ON_CYCLES)
      ) u_sw (
         .ref_clk(ref_clk),
         .rst(rst),
         .enable(switchEnable[g]),
         .forcePwm(railPwm[g]),
         .belowThreshold(belowThreshold[g]),
         .peakLimit(peakLimit[g]),
         .negLimit(negLimit[g]),
         .zeroCross(zeroCross[g]),
         .highSide(highSide[g]),
         .lowSide(lowSide[g])
      );
   end

   // registered rail status outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         power_good_flag <= '0;
         pwmForced <= '0;
         voltage_id_code <= '0;
      end else begin
         power_good_flag <= power_good_flag_d;
         pwmForced <= pwmForced_d;
         for (int r = 0; r < NUM_RAILS; r++) begin
            voltage_id_code[r*CODE_W +: CODE_W] <= railCode[r];
         end
      end
   end
endmodule // buck_dvs_decay_sequencer

//--- buck_dvs_decay_sequencer_properties.sv
// port-level checks of the sequencer, timed ones on rail 0
module seq_properties import buck_seq_pkg::*; #(
   parameter int FINE_CYCLES = 4,
   parameter int MIN_ON_CYCLES = 3
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // watched ports
   input wire logic [5:0] belowThreshold,
   input wire logic [5:0] peakLimit,
   input wire logic [5:0] negLimit,
   input wire logic [5:0] powerGoodRaw,
   input wire logic [5:0] highSide,
   input wire logic [5:0] lowSide,
   input wire logic [5:0] power_good_flag,
   input wire logic [5:0] pwmForced,
   input wire logic [41:0] voltage_id_code
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [6:0] code, prevCode_q;
   logic prevPwm_q, chg;
   logic [7:0] gap_q, gap_d, onCnt_q, onCnt_d;
   assign code = voltage_id_code[6:0];
   assign chg = code != prevCode_q && pwmForced[0] && prevPwm_q;
   // counters saturate so long idle spans never wrap into a false short gap
   always_comb begin
      gap_d = (code != prevCode_q) ? 8'h01 : (gap_q == 8'hFF ? gap_q : gap_q + 8'h01);
      onCnt_d = !highSide[0] ? 8'h00 : (onCnt_q == 8'hFF ? onCnt_q : onCnt_q + 8'h01);
   end
   always_ff @(posedge ref_clk) begin
      prevCode_q <= code;
      prevPwm_q <= rst ? 1'h0 : pwmForced[0];
      gap_q <= rst ? 8'hFF : gap_d;
      onCnt_q <= rst ? 8'h00 : onCnt_d;
   end
   step_spacing_a:
      assert property (chg |-> gap_q >= FINE_CYCLES) else $error("code stepped too soon");
   step_size_a:
      assert property (chg |-> code == prevCode_q + 7'h01 || code == prevCode_q - 7'h01 || code == CODE_HALF_VOLT)
      else $error("code jumped");
   good_masked_a:
      assert property (pwmForced[0] && prevPwm_q |-> !power_good_flag[0]) else $error("good shown in move");
   good_source_a:
      assert property (power_good_flag[0] |-> $past(powerGoodRaw[0])) else $error("good without comparator");
   no_overlap_a:
      assert property ((highSide & lowSide) == 6'h00) else $error("both switches on");
   low_after_high_a:
      assert property ($rose(lowSide[0]) |-> $fell(highSide[0])) else $error("low side on without pulse");
   high_start_a:
      assert property (pwmForced[0] && prevPwm_q && belowThreshold[0] && !peakLimit[0] && !highSide[0]
         |=> highSide[0] || !pwmForced[0]) else $error("pulse not started");
   min_on_a:
      assert property (highSide[0] && onCnt_q < MIN_ON_CYCLES - 1 && !peakLimit[0] && pwmForced[0]
         |=> highSide[0] || !pwmForced[0]) else $error("pulse too short");
   neg_limit_a:
      assert property (lowSide[0] && negLimit[0] |=> !lowSide[0]) else $error("low side kept on");
   cover property (chg && code == CODE_HALF_VOLT);
   cover property (lowSide[0] && negLimit[0]);
   cover property ($fell(pwmForced[0]));
endmodule // seq_properties

//--- buck_dvs_decay_sequencer_tb.sv
// self-checking bench of the six-rail voltage sequencer
module buck_dvs_decay_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import buck_seq_pkg::*;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] address = 8'h00;
   logic read = 1'h0;
   logic write = 1'h0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] readdata, rd;
   logic waitrequest, irq;
   logic [5:0] belowThreshold, peakLimit, negLimit, zeroCross, outBelowHalfVolt, outBelowOverVolt;
   logic [5:0] outAboveCode, powerGoodRaw, highSide, lowSide, power_good_flag, pwmForced;
   logic [5:0] negTrip = 6'h00;
   logic [41:0] voltage_id_code;
   int numErrors = 0;
   int compares = 0;
   int cycles = 0;
   int seed = 7022;
   int tgt[6]; // model: settled code of each rail
   buck_dvs_decay_sequencer #(.SOFT_START_CYCLES(50), .FINE_CYCLES(4), .COARSE_CYCLES(8), .MIN_ON_CYCLES(3))
      buck_dvs_decay_sequencer_i (.ref_clk, .rst, .address, .read, .write, .writedata, .byteenable, .readdata,
      .waitrequest, .irq, .belowThreshold, .peakLimit, .negLimit, .zeroCross, .outBelowHalfVolt,
      .outBelowOverVolt, .outAboveCode, .powerGoodRaw, .highSide, .lowSide, .power_good_flag, .pwmForced,
      .voltage_id_code);
   power_stage_model power_stage_model_i (.ref_clk, .highSide, .lowSide, .voltage_id_code, .negTrip,
      .belowThreshold, .peakLimit, .negLimit, .zeroCross, .outBelowHalfVolt, .outBelowOverVolt, .outAboveCode,
      .powerGoodRaw);
   // clock, 5 ns period
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   // hang guard, far above the expected run length
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         numErrors++;
         conclude();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         numErrors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // one bus access; waits for waitrequest low, then releases
   task automatic busCycle(input logic wr, input logic [7:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do @(posedge ref_clk); while (waitrequest !== 1'h0);
      rd = readdata;
      read <= 1'h0;
      write <= 1'h0;
      @(posedge ref_clk);
   endtask
   task automatic readCheck(input string what, input logic [7:0] a, input logic [31:0] exp);
      busCycle(1'h0, a, 32'h0);
      check(what, rd, exp);
   endtask
   task automatic setRail(input int r, input logic [31:0] v);
      busCycle(1'h1, ADDR_CTRL_BASE + 8'(4 * r), v);
   endtask
   // polls the moving flag, bounded
   task automatic settle(input int r);
      int n;
      n = 0;
      do begin
         busCycle(1'h0, ADDR_STAT_BASE + 8'(4 * r), 32'h0);
         n++;
      end while (rd[STAT_MOVING_BIT] !== 1'h0 && n < 400);
   endtask
   task automatic railDone(input int r);
      settle(r);
      check("rail status", rd, 32'h200 | 32'(tgt[r]));
      check("rail code", 32'(voltage_id_code[7 * r +: 7]), 32'(tgt[r]));
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, numErrors);
      if (numErrors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'h0;
      @(posedge ref_clk);
      readCheck("target reg", ADDR_CTRL_BASE, 32'h0);
      readCheck("mask reg", ADDR_IRQ_MASK, 32'h0);
      busCycle(1'h1, 8'h80, 32'hFFFFFFFF);
      readCheck("unmapped", 8'h80, 32'h0);
      readCheck("reset status", ADDR_STAT_BASE, 32'h1);
      $display("test reset done");
      // random targets on all rails from zero volts, fine or coarse
      busCycle(1'h1, ADDR_IRQ_MASK, 32'h3F);
      for (int r = 0; r < 6; r++) begin
         tgt[r] = 5 + (($random(seed) & 32'h7FFF) % 40);
         setRail(r, 32'(tgt[r]) | (32'($random(seed) & 1) << CTRL_COARSE_BIT));
      end
      repeat (20) @(posedge ref_clk);
      check("soft start hold", 32'(voltage_id_code[6:0]), 32'h1);
      check("forced pwm", 32'(pwmForced[0]), 32'h1);
      check("good masked", 32'(power_good_flag[0]), 32'h0);
      for (int r = 0; r < 6; r++) begin
         railDone(r);
      end
      readCheck("event status", ADDR_IRQ_STAT, 32'h3F);
      check("irq raised", 32'(irq), 32'h1);
      busCycle(1'h1, ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge ref_clk);
      check("irq masked", 32'(irq), 32'h0);
      busCycle(1'h1, ADDR_IRQ_STAT, 32'h3F);
      busCycle(1'h1, ADDR_IRQ_MASK, 32'h1);
      readCheck("status cleared", ADDR_IRQ_STAT, 32'h0);
      $display("test scaling done");
      // redirect a long move about ten cycles in, then trip the negative limit
      tgt[0] = 32;
      setRail(0, 32'h38);
      repeat (10) @(posedge ref_clk);
      check("forced pwm", 32'(pwmForced[0]), 32'h1);
      check("good masked", 32'(power_good_flag[0]), 32'h0);
      setRail(0, 32'h20);
      railDone(0);
      negTrip <= 6'h01;
      repeat (30) @(posedge ref_clk);
      negTrip <= 6'h00;
      $display("test redirect done");
      // decay down, then an upward move with decay still set
      busCycle(1'h1, ADDR_IRQ_STAT, 32'h3F);
      tgt[0] = 8;
      setRail(0, 32'h88);
      repeat (3) @(posedge ref_clk);
      check("decay code", 32'(voltage_id_code[6:0]), 32'h8);
      check("switches idle", 32'(highSide[0] | lowSide[0]), 32'h0);
      check("no pwm in decay", 32'(pwmForced[0]), 32'h0);
      check("good masked", 32'(power_good_flag[0]), 32'h0);
      railDone(0);
      check("irq after decay", 32'(irq), 32'h1);
      tgt[0] = 16;
      setRail(0, 32'h90);
      repeat (3) @(posedge ref_clk);
      check("stepped rise", 32'(voltage_id_code[6:0] < 7'h0A), 32'h1);
      railDone(0);
      // upward command while still decaying waits with switches off
      setRail(0, 32'h84);
      repeat (3) @(posedge ref_clk);
      tgt[0] = 12;
      setRail(0, 32'h8C);
      busCycle(1'h0, ADDR_STAT_BASE, 32'h0);
      check("catch wait", 32'(rd[STAT_SWITCHING_BIT]), 32'h0);
      railDone(0);
      $display("test decay done");
      // zero target ends switching; a later target soft-starts again
      setRail(0, 32'h0);
      settle(0);
      check("off status", rd, 32'h1);
      check("off switches", 32'(highSide[0]), 32'h0);
      repeat (60) @(posedge ref_clk);
      tgt[0] = 6;
      setRail(0, 32'h6);
      railDone(0);
      $display("test off and restart done");
      conclude();
   end
endmodule // buck_dvs_decay_sequencer_tb
bind buck_dvs_decay_sequencer seq_properties #(.FINE_CYCLES(FINE_CYCLES), .MIN_ON_CYCLES(MIN_ON_CYCLES))
   seq_properties_i (.ref_clk, .rst, .belowThreshold, .peakLimit, .negLimit, .powerGoodRaw, .highSide, .lowSide,
   .power_good_flag, .pwmForced, .voltage_id_code);

//--- buck_seq_pkg.sv
// shared constants for the six-rail voltage sequencer
package buck_seq_pkg;
   localparam int NUM_RAILS = 6;
   localparam int CODE_W = 7;
   localparam int CLK_PERIOD_PS = 5000;
   // stepping and soft-start times in ns, as specified
   localparam int STEP_FINE_NS = 3000;
   localparam int STEP_COARSE_NS = 6000;
   localparam int SOFT_START_NS = 200000;
   // cycle counts, least times rounded up
   localparam int STEP_FINE_CYC = (STEP_FINE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STEP_COARSE_CYC = (STEP_COARSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SOFT_START_CYC = (SOFT_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int MIN_ON_CYC = 20;
   // special codes
   localparam logic [6:0] CODE_OFF = 7'h00;
   localparam logic [6:0] CODE_MIN = 7'h01;
   localparam logic [6:0] CODE_HALF_VOLT = 7'h04;
   // register map, byte addresses
   localparam logic [7:0] ADDR_CTRL_BASE = 8'h00;
   localparam logic [7:0] ADDR_STAT_BASE = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h40;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
   // control register fields
   localparam int CTRL_TARGET_LSB = 0;
   localparam int CTRL_DECAY_BIT = 7;
   localparam int CTRL_COARSE_BIT = 8;
   // status register fields
   localparam int STAT_CODE_LSB = 0;
   localparam int STAT_MOVING_BIT = 8;
   localparam int STAT_SWITCHING_BIT = 9;
   localparam int STAT_PWM_BIT = 10;
   // reset values
   localparam logic [6:0] TARGET_RESET = 7'h00;
   localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
   // sequencer states
   typedef enum logic [2:0] {
      RAIL_OFF,
      RAIL_SOFTSTART,
      RAIL_STEP,
      RAIL_DECAY,
      RAIL_IDLE
   } rail_state_type;
endpackage

//--- power_stage_model.sv
// behavioural power stage, inductor and output filter of every rail
module power_stage_model (
   // clock
   input wire logic ref_clk,
   // switch drives, code and a forced limit trip
   input wire logic [5:0] highSide,
   input wire logic [5:0] lowSide,
   input wire logic [41:0] voltage_id_code,
   input wire logic [5:0] negTrip,
   // comparator outputs
   output logic [5:0] belowThreshold,
   output logic [5:0] peakLimit,
   output logic [5:0] negLimit,
   output logic [5:0] zeroCross,
   output logic [5:0] outBelowHalfVolt,
   output logic [5:0] outBelowOverVolt,
   output logic [5:0] outAboveCode,
   output logic [5:0] powerGoodRaw
);
   timeunit 1ns;
   timeprecision 1ps;
   int vout[6]; // output in quarter code steps
   int cur[6]; // inductor current
   // with both switches off the load drains the output, never below zero
   always @(posedge ref_clk) begin
      int c, v;
      for (int r = 0; r < 6; r++) begin
         c = highSide[r] ? cur[r] + 2 : (lowSide[r] ? cur[r] - 1 : 0);
         v = vout[r] + (c > 0 ? 1 : -1);
         cur[r] <= c;
         vout[r] <= v < 0 ? 0 : v;
      end
   end
   // comparators against the level of the present code, a fixed half-volt level and the inductor current
   always_comb begin
      int lvl;
      lvl = 0;
      for (int r = 0; r < 6; r++) begin
         lvl = 4 * int'(voltage_id_code[7 * r +: 7]);
         belowThreshold[r] = vout[r] < lvl;
         outBelowHalfVolt[r] = vout[r] < 16;
         outBelowOverVolt[r] = vout[r] < lvl + 8;
         outAboveCode[r] = vout[r] > lvl;
         powerGoodRaw[r] = vout[r] > lvl - 8 && vout[r] < lvl + 8;
         peakLimit[r] = cur[r] >= 8;
         negLimit[r] = cur[r] <= -6 || negTrip[r];
         zeroCross[r] = cur[r] <= 0;
      end
   end
endmodule // power_stage_model

//--- rail_switch_ctrl.sv
// one rail's high-side / low-side switch pulse decisions
module rail_switch_ctrl #(
   parameter int MIN_ON_CYCLES = buck_seq_pkg::MIN_ON_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // control from the sequencer
   input wire logic enable,
   input wire logic forcePwm,
   // analog comparators
   input wire logic belowThreshold,
   input wire logic peakLimit,
   input wire logic negLimit,
   input wire logic zeroCross,
   // switch drives
   output logic highSide,
   output logic lowSide
);
   import buck_seq_pkg::*;

   if (MIN_ON_CYCLES < 1 || MIN_ON_CYCLES > 255) begin : g_chk
      $error("rail_switch_ctrl: MIN_ON_CYCLES out of range");
   end

   logic [7:0] onCnt_q, onCnt_d;
   logic highSide_d, lowSide_d, lsBlocked_q, lsBlocked_d;
   logic minOnDone;

   always_comb begin
      minOnDone = (onCnt_q >= 8'(MIN_ON_CYCLES));
      highSide_d = highSide;
      lowSide_d = lowSide;
      lsBlocked_d = lsBlocked_q;
      onCnt_d = onCnt_q;
      if (!enable) begin
         // both switches off: no regulation at all
         highSide_d = 1'b0;
         lowSide_d = 1'b0;
         lsBlocked_d = 1'b0;
         onCnt_d = 8'h00;
      end else if (highSide) begin
         onCnt_d = minOnDone ? onCnt_q : onCnt_q + 8'h01;
         if ((minOnDone && !belowThreshold) || peakLimit) begin
            highSide_d = 1'b0;
            lowSide_d = 1'b1;
            lsBlocked_d = 1'b0;
         end
      end else if (belowThreshold) begin
         // new pulse ends any low-side phase
         highSide_d = 1'b1;
         lowSide_d = 1'b0;
         onCnt_d = 8'h00;
      end else begin
         // pwm keeps low side on through negative current; pfm stops at zero
         if (negLimit || (!forcePwm && zeroCross)) begin
            lsBlocked_d = 1'b1;
         end
         lowSide_d = lowSide && !lsBlocked_d && !(negLimit || (!forcePwm && zeroCross));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         highSide <= 1'b0;
         lowSide <= 1'b0;
         lsBlocked_q <= 1'b0;
         onCnt_q <= 8'h00;
      end else begin
         highSide <= highSide_d;
         lowSide <= lowSide_d;
         lsBlocked_q <= lsBlocked_d;
         onCnt_q <= onCnt_d;
      end
   end
endmodule // rail_switch_ctrl

//--- step_tick_divider.sv
// divider making the fine and coarse code-step enable pulses
module step_tick_divider #(
   parameter int FINE_CYCLES = buck_seq_pkg::STEP_FINE_CYC,
   parameter int COARSE_CYCLES = buck_seq_pkg::STEP_COARSE_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // step enables
   output logic fineTick,
   output logic coarseTick
);
   import buck_seq_pkg::*;

   if (FINE_CYCLES < 2 || COARSE_CYCLES < 2 || FINE_CYCLES > 65535 || COARSE_CYCLES > 65535) begin : g_chk
      $error("step_tick_divider: cycle counts out of range");
   end

   logic [15:0] fineCnt_q, fineCnt_d, coarseCnt_q, coarseCnt_d;
   logic fineTick_d, coarseTick_d;

   // free-running counters; pulse on wrap
   always_comb begin
      fineTick_d = (fineCnt_q == 16'(FINE_CYCLES - 1));
      coarseTick_d = (coarseCnt_q == 16'(COARSE_CYCLES - 1));
      fineCnt_d = fineTick_d ? 16'h0000 : fineCnt_q + 16'h0001;
      coarseCnt_d = coarseTick_d ? 16'h0000 : coarseCnt_q + 16'h0001;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fineCnt_q <= 16'h0000;
         coarseCnt_q <= 16'h0000;
         fineTick <= 1'b0;
         coarseTick <= 1'b0;
      end else begin
         fineCnt_q <= fineCnt_d;
         coarseCnt_q <= coarseCnt_d;
         fineTick <= fineTick_d;
         coarseTick <= coarseTick_d;
      end
   end
endmodule // step_tick_divider
